// ### design/twe_pkg.sv
// Shared constants and types for the two-wire EEPROM write port
package twe_pkg;

    localparam int           ADDR_W        = 16;
    localparam int           BYTE_W        = 8;
    localparam int           IDX_W         = 7;
    localparam int           PAGE_W        = 9;
    localparam int           PAGE_BYTES    = 128;
    localparam int           CS_W          = 3;
    localparam int           TYPE_W        = 4;
    localparam logic [3:0]   DEV_TYPE_DFLT = 4'hA;

    // Device address word layout, bit 7 first on the wire
    localparam int           RW_POS        = 0;
    localparam int           CS_LSB        = 1;
    localparam int           TYPE_LSB      = 4;

    // Bit counter values within one nine-clock word
    localparam logic [3:0]   CNT_ARM       = 4'h6;
    localparam logic [3:0]   CNT_BYTE      = 4'h7;
    localparam logic [3:0]   CNT_ACK       = 4'h8;

    // Programming cycle time
    localparam int           MCLK_PERIOD_NS = 25;
    localparam int           PROG_TIME_MS   = 5;
    localparam int           PROG_CYCLES    =
        PROG_TIME_MS * 1000000 / MCLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADDR,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_DATA,
        ST_IGNORE,
        ST_PROG
    } twe_state_t;

endpackage

// ### design/twe_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none

module twe_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } twe_sync_st_t;

    twe_sync_st_t r;
    twe_sync_st_t nxt_r;

    always_comb begin
        nxt_r    = r;
        nxt_r.s1 = d;
        nxt_r.s2 = r.s1;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else if (ce) begin
            r <= nxt_r;
        end
    end

    assign q = r.s2;

endmodule

`default_nettype wire

// ### design/twe_page_buf.sv
// Page buffer: one page of received bytes with a per-byte valid mask
`timescale 1ns/10ps
`default_nettype none

module twe_page_buf
    import twe_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    input  wire logic              clr,
    input  wire logic              wr_en,
    input  wire logic [IDX_W-1:0]  wr_idx,
    input  wire logic [BYTE_W-1:0] wr_data,
    input  wire logic [IDX_W-1:0]  rd_idx,
    output logic      [BYTE_W-1:0] rd_data,
    output logic                   rd_valid
);

    typedef struct packed {
        logic [PAGE_BYTES-1:0][BYTE_W-1:0] mem;
        logic [PAGE_BYTES-1:0]             vld;
    } twe_pbuf_st_t;

    twe_pbuf_st_t r;
    twe_pbuf_st_t nxt_r;

    // A write in the clearing cycle still lands, so no byte is lost
    always_comb begin
        nxt_r = r;
        if (clr) begin
            nxt_r.vld = '0;
        end
        if (wr_en) begin
            nxt_r.mem[wr_idx] = wr_data;
            nxt_r.vld[wr_idx] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else if (ce) begin
            r <= nxt_r;
        end
    end

    assign rd_data  = r.mem[rd_idx];
    assign rd_valid = r.vld[rd_idx];

endmodule

`default_nettype wire

// ### design/twe_write_port.sv
// Two-wire EEPROM target: addressing, acknowledge, page write, programming
`timescale 1ns/10ps
`default_nettype none

module twe_write_port
    import twe_pkg::*;
#(
    parameter logic [TYPE_W-1:0] DEV_TYPE    = DEV_TYPE_DFLT,
    parameter int                PROG_CNT    = PROG_CYCLES
) (
    input  wire logic              MCLK,
    input  wire logic              RST_B,
    input  wire logic              CE,
    input  wire logic              SCL,
    input  wire logic              SDA_I,
    input  wire logic              WP,
    input  wire logic [CS_W-1:0]   CHIP_SEL,
    output logic                   SDA_O,
    output logic                   SDA_OE,
    output logic                   MEM_WE,
    output logic      [ADDR_W-1:0] MEM_ADDR,
    output logic      [BYTE_W-1:0] MEM_WDATA,
    output logic                   BUSY,
    output logic                   STANDBY
);
    import twe_pkg::*;

    localparam int TMR_W = $clog2(PROG_CNT + 1);

    ////////////////////////////////////////////////////////////////////////
    // Link side, clocked by SCL

    typedef struct packed {
        logic rx_bit;
        logic rx_tgl;
    } twe_lnk_rx_t;

    typedef struct packed {
        logic drive;
        logic lvl;
    } twe_lnk_tx_t;

    twe_lnk_rx_t lrx;
    twe_lnk_rx_t nxt_lrx;
    twe_lnk_tx_t ltx;
    twe_lnk_tx_t nxt_ltx;

    typedef struct packed {
        twe_state_t        state;
        logic [BYTE_W-1:0] sr;
        logic [3:0]        cnt;
        logic              ack_arm;
        logic [ADDR_W-1:0] addr;
        logic              wrote;
        logic [IDX_W:0]    scan;
        logic [TMR_W-1:0]  tmr;
        logic              pscl;
        logic              psda;
        logic              ptgl;
        logic              mem_we;
        logic [ADDR_W-1:0] mem_addr;
        logic [BYTE_W-1:0] mem_wdata;
        logic              busy;
        logic              standby;
    } twe_core_t;

    twe_core_t r;
    twe_core_t nxt_r;

    // Each rising edge captures one bit and flips the event toggle
    always_comb begin
        nxt_lrx        = lrx;
        nxt_lrx.rx_bit = SDA_I;
        nxt_lrx.rx_tgl = ~lrx.rx_tgl;
    end

    always_ff @(posedge SCL or negedge RST_B) begin
        if (!RST_B) begin
            lrx <= '0;
        end else begin
            lrx <= nxt_lrx;
        end
    end

    // The arm level is set on the third MCLK edge after the rising edge, within the SCL high phase ahead of the falling edge
    // that uses it and cleared only after it has been used, so it is
    // stable whenever this edge samples it.
    // Low for one SCL period: from the falling edge after the eighth bit
    // to the falling edge after the ninth.
    always_comb begin
        nxt_ltx       = ltx;
        nxt_ltx.lvl   = 1'b0;
        nxt_ltx.drive = r.ack_arm & ~ltx.drive;
    end

    always_ff @(negedge SCL or negedge RST_B) begin
        if (!RST_B) begin
            ltx <= '0;
        end else begin
            ltx <= nxt_ltx;
        end
    end

    assign SDA_O  = ltx.lvl;
    assign SDA_OE = ltx.drive;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and page buffer

    logic              scl_s;
    logic              sda_s;
    logic              tgl_s;
    logic              wp_s;
    logic [CS_W-1:0]   cs_s;
    logic              pb_clr;
    logic              pb_wr;
    logic [BYTE_W-1:0] pb_rd_data;
    logic              pb_rd_vld;
    logic [BYTE_W-1:0] rx_byte;

    twe_sync #(
        .W (4 + CS_W)
    ) u_sync (
        .clk   (MCLK),
        .rst_b (RST_B),
        .ce    (CE),
        .d     ({SCL, SDA_I, lrx.rx_tgl, WP, CHIP_SEL}),
        .q     ({scl_s, sda_s, tgl_s, wp_s, cs_s})
    );

    twe_page_buf u_pbuf (
        .clk      (MCLK),
        .rst_b    (RST_B),
        .ce       (CE),
        .clr      (pb_clr),
        .wr_en    (pb_wr),
        .wr_idx   (r.addr[IDX_W-1:0]),
        .wr_data  (rx_byte),
        .rd_idx   (r.scan[IDX_W-1:0]),
        .rd_data  (pb_rd_data),
        .rd_valid (pb_rd_vld)
    );

    ////////////////////////////////////////////////////////////////////////
    // Protocol engine

    // Pattern and chip-select check of the first seven address bits;
    // floating select pins are pulled low outside this logic
    function automatic logic dev_match(input logic [6:0] w,
                                       input logic [CS_W-1:0] cs);
        dev_match = (w[6:3] == DEV_TYPE) && (w[2:0] == cs);
    endfunction

    logic start_ev;
    logic stop_ev;
    logic bit_ev;

    // Conditions come from SDA moving while SCL stays high
    assign start_ev = scl_s & r.pscl & r.psda & ~sda_s;
    assign stop_ev  = scl_s & r.pscl & ~r.psda & sda_s;
    assign bit_ev   = tgl_s ^ r.ptgl;
    assign rx_byte  = {r.sr[BYTE_W-2:0], lrx.rx_bit};

    always_comb begin
        nxt_r        = r;
        nxt_r.pscl   = scl_s;
        nxt_r.psda   = sda_s;
        nxt_r.ptgl   = tgl_s;
        nxt_r.mem_we = 1'b0;
        pb_clr       = 1'b0;
        pb_wr        = 1'b0;
        if (r.state == ST_PROG) begin
            // All bus activity is ignored until programming ends
            if (r.scan != (IDX_W + 1)'(PAGE_BYTES)) begin
                if (pb_rd_vld) begin
                    nxt_r.mem_we    = 1'b1;
                    nxt_r.mem_addr  = {r.addr[ADDR_W-1:IDX_W],
                                       r.scan[IDX_W-1:0]};
                    nxt_r.mem_wdata = pb_rd_data;
                end
                nxt_r.scan = r.scan + 1'b1;
            end
            if (r.tmr >= TMR_W'(PROG_CNT - 1) &&
                r.scan == (IDX_W + 1)'(PAGE_BYTES)) begin
                nxt_r.state = ST_IDLE;
            end else begin
                nxt_r.tmr = r.tmr + 1'b1;
            end
        end else if (start_ev) begin
            nxt_r.state   = ST_DEVADDR;
            nxt_r.cnt     = '0;
            nxt_r.ack_arm = 1'b0;
            nxt_r.wrote   = 1'b0;
            pb_clr        = 1'b1;
        end else if (stop_ev) begin
            nxt_r.ack_arm = 1'b0;
            if (r.state == ST_DATA && r.wrote) begin
                nxt_r.state = ST_PROG;
                nxt_r.scan  = '0;
                nxt_r.tmr   = '0;
            end else begin
                nxt_r.state = ST_IDLE;
            end
        end else if (bit_ev && r.state != ST_IDLE &&
                     (r.state != ST_IGNORE || r.cnt == CNT_ACK)) begin
            if (r.cnt == CNT_ACK) begin
                nxt_r.cnt     = '0;
                nxt_r.ack_arm = 1'b0;
            end else begin
                nxt_r.sr  = rx_byte;
                nxt_r.cnt = r.cnt + 1'b1;
                if (r.cnt == CNT_BYTE) begin
                    // Armed after bit eight so the next fall drives it
                    nxt_r.ack_arm = (r.state != ST_DEVADDR) ||
                                    dev_match(rx_byte[7:1], cs_s);
                    unique case (r.state)
                        ST_DEVADDR: begin
                            if (!dev_match(rx_byte[7:1], cs_s)) begin
                                nxt_r.state = ST_IDLE;
                            end else if (rx_byte[RW_POS]) begin
                                nxt_r.state = ST_IGNORE;
                            end else begin
                                nxt_r.state = ST_ADDR_HI;
                            end
                        end
                        ST_ADDR_HI: begin
                            nxt_r.addr[ADDR_W-1:BYTE_W] = rx_byte;
                            nxt_r.state = ST_ADDR_LO;
                        end
                        ST_ADDR_LO: begin
                            nxt_r.addr[BYTE_W-1:0] = rx_byte;
                            nxt_r.state = ST_DATA;
                        end
                        ST_DATA: begin
                            if (!wp_s) begin
                                pb_wr       = 1'b1;
                                nxt_r.wrote = 1'b1;
                            end
                            nxt_r.addr[IDX_W-1:0] =
                                r.addr[IDX_W-1:0] + 1'b1;
                        end
                        default: begin
                            nxt_r.state = ST_IDLE;
                        end
                    endcase
                end
            end
        end
        nxt_r.busy    = (nxt_r.state == ST_PROG);
        nxt_r.standby = (nxt_r.state == ST_IDLE);
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            r         <= '0;
            r.state   <= ST_IDLE;
            r.standby <= 1'b1;
        end else if (CE) begin
            r <= nxt_r;
        end
    end

    assign MEM_WE    = r.mem_we;
    assign MEM_ADDR  = r.mem_addr;
    assign MEM_WDATA = r.mem_wdata;
    assign BUSY      = r.busy;
    assign STANDBY   = r.standby;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb_mclk @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    a_arm_on_match: assert property (
        CE && bit_ev && r.state == ST_DEVADDR && r.cnt == CNT_BYTE &&
        !dev_match(rx_byte[7:1], cs_s) |=> !r.ack_arm)
        else $error("address acknowledge armed on a mismatch");

    a_busy_silent: assert property (
        r.state == ST_PROG |-> !r.ack_arm && !pb_wr)
        else $error("acknowledge armed while programming");

    a_wp_no_write: assert property (
        CE && bit_ev && r.state == ST_DATA && r.cnt == CNT_BYTE && wp_s
        |=> !r.wrote || $past(r.wrote))
        else $error("write accepted while write-protected");

    a_page_fixed: assert property (
        CE && bit_ev && r.state == ST_DATA && r.cnt == CNT_BYTE
        |=> r.addr[ADDR_W-1:IDX_W] == $past(r.addr[ADDR_W-1:IDX_W]) &&
            r.addr[IDX_W-1:0] == $past(r.addr[IDX_W-1:0]) + 7'h1)
        else $error("page bits moved or offset not advanced");

    a_prog_bound: assert property (
        r.tmr <= TMR_W'(PROG_CNT))
        else $error("programming timer ran past its length");

    a_start_restart: assert property (
        CE && start_ev && r.state != ST_PROG
        |=> r.state == ST_DEVADDR && r.cnt == 4'h0 && !r.ack_arm)
        else $error("start did not restart the engine");

    a_stop_standby: assert property (
        CE && stop_ev && r.state == ST_IGNORE |=> r.standby && !r.busy)
        else $error("stop after read left standby off");

    a_mismatch_idle: assert property (
        CE && bit_ev && r.state == ST_DEVADDR && r.cnt == CNT_BYTE &&
        !dev_match(rx_byte[7:1], cs_s) |=> r.state == ST_IDLE)
        else $error("mismatched address did not return to standby");

    a_we_in_prog: assert property (
        r.mem_we |-> r.busy && $past(pb_rd_vld))
        else $error("array write outside programming or unreceived");

    a_arm_window: assert property (
        r.ack_arm |-> r.cnt == CNT_BYTE || r.cnt == CNT_ACK)
        else $error("acknowledge armed outside the ninth clock");

    a_ack_one_clk: assert property (
        @(negedge SCL) disable iff (!RST_B) ltx.drive |=> !ltx.drive)
        else $error("acknowledge held longer than one clock");

endmodule

`default_nettype wire

// ### verification/twe_ctrl_model.sv
// Behavioural two-wire bus controller: drives SCL, pulls SDA low or releases
`timescale 1ns/10ps
`default_nettype none

module twe_ctrl_model (
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);

    // Bus idles with SCL high and SDA released; SCL only runs in frames
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic start();
        sda_low = 1'b0;
        #40 scl = 1'b1;
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
        #40;
    endtask

    task automatic stop();
        sda_low = 1'b1;
        #40 scl = 1'b1;
        #40 sda_low = 1'b0;
        #80;
    endtask

    // Data set while SCL is low, line read in the middle of SCL high
    task automatic clk_bit(input logic b, output logic s);
        sda_low = ~b;
        #40 scl = 1'b1;
        #40 s = sda;
        #40 scl = 1'b0;
        #40;
    endtask

    // Bytes go MSB first; ninth clock released for the target's answer
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask

    // Clock with SDA released until it reads high, at most 9 times
    task automatic recover(output logic ok);
        logic s;
        ok = 1'b0;
        for (int i = 0; i < 9 && !ok; i++) begin
            clk_bit(1'b1, s);
            ok = (s === 1'b1);
        end
        start();
    endtask

endmodule

`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the two-wire EEPROM write port
`timescale 1ns/10ps
`default_nettype none

module tb;
    import twe_pkg::*;

    localparam int PROG_C = 200;

    logic              mclk     = 1'b0;
    logic              rst_b    = 1'b0;
    logic              wp       = 1'b0;
    logic [CS_W-1:0]   chip_sel = '0;
    wire logic         scl;
    wire logic         ctl_low;
    wire logic         sda_w;
    wire logic         sda_o;
    wire logic         sda_oe;
    wire logic         mem_we;
    wire logic         busy;
    wire logic         standby;
    wire logic [ADDR_W-1:0] mem_addr;
    wire logic [BYTE_W-1:0] mem_wdata;
    int                error_cnt = 0;
    int                samples_checked = 0;
    int                busy_hits = 0;
    int                h;
    logic              k;
    logic [23:0]       wq[$];
    logic [7:0]        exp_d[128];
    logic              exp_v[128];

    // Pull-up wire: low when either party pulls it
    assign sda_w = ~(ctl_low | (sda_oe & ~sda_o));

    always #12.5 mclk = ~mclk;

    twe_ctrl_model m (.sda(sda_w), .scl(scl), .sda_low(ctl_low));

    twe_write_port #(.DEV_TYPE(DEV_TYPE_DFLT), .PROG_CNT(PROG_C)) dut (
        .MCLK(mclk), .RST_B(rst_b), .CE(1'b1), .SCL(scl), .SDA_I(sda_w),
        .WP(wp), .CHIP_SEL(chip_sel), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
        .BUSY(busy), .STANDBY(standby));

    always @(posedge mclk) begin
        if (mem_we === 1'b1) wq.push_back({mem_addr, mem_wdata});
        if (busy === 1'b1) busy_hits++;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic addr_frame(input logic rw, input logic [3:0] ty,
                              input logic [2:0] cs, input logic exp);
        logic a;
        m.start();
        m.send_byte({ty, cs, rw}, a);
        chk(a, exp);
    endtask

    task automatic do_write(input logic [15:0] a, input int n,
                            input logic [7:0] sd);
        logic [6:0] o;
        h = busy_hits;
        addr_frame(1'b0, DEV_TYPE_DFLT, chip_sel, 1'b1);
        m.send_byte(a[15:8], k); chk(k, 1);
        m.send_byte(a[7:0], k); chk(k, 1);
        for (int i = 0; i < n; i++) begin
            m.send_byte(sd + i[7:0], k); chk(k, 1);
            o = a[6:0] + i[6:0];
            exp_v[o] = 1'b1;
            exp_d[o] = sd + i[7:0];
        end
        m.stop();
    endtask

    task automatic check_prog(input logic [PAGE_W-1:0] pg);
        int n;
        int nv;
        for (n = 0; n < 40 && busy !== 1'b1; n++) @(negedge mclk);
        if (busy !== 1'b1) begin
            error_cnt++;
            finish_test();
        end
        chk(standby, 0);
        for (n = 0; n < 1000 && busy === 1'b1; n++) @(negedge mclk);
        chk(busy_hits - h, PROG_C);
        repeat (2) @(negedge mclk);
        chk(standby, 1);
        nv = 0;
        foreach (exp_v[o]) nv += exp_v[o];
        chk(wq.size(), nv);
        for (int o = 0; o < 128; o++) begin
            if (exp_v[o] && wq.size() > 0) begin
                chk(wq.pop_front(), {pg, o[6:0], exp_d[o]});
            end
            exp_v[o] = 1'b0;
        end
        wq.delete();
    endtask

    initial begin
        #1_000_000;
        error_cnt++;
        finish_test();
    end

    initial begin
        foreach (exp_v[o]) exp_v[o] = 1'b0;
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        repeat (6) @(negedge mclk);
        chk({standby, busy, sda_oe, mem_we}, 4'h8);
        addr_frame(1'b0, 4'hB, 3'h0, 1'b0);
        m.stop();
        chk(standby, 1);
        // Every strap value, with a wrong and a right address word
        for (int c = 0; c < 8; c++) begin
            @(negedge mclk);
            chip_sel = c[2:0];
            repeat (4) @(negedge mclk);
            addr_frame(1'b0, DEV_TYPE_DFLT, c[2:0] ^ 3'h2, 1'b0);
            m.stop();
            chk(standby, 1);
            addr_frame(1'b0, DEV_TYPE_DFLT, c[2:0], 1'b1);
            m.stop();
        end
        chk(wq.size(), 0);
        @(negedge mclk);
        chip_sel = 3'h5;
        repeat (4) @(negedge mclk);
        do_write({9'h1F5, 7'h7F}, 3, 8'h5A);
        check_prog(9'h1F5);
        do_write({9'h003, 7'h10}, 1, 8'hC3);
        addr_frame(1'b0, DEV_TYPE_DFLT, chip_sel, 1'b0);
        m.stop();
        check_prog(9'h003);
        addr_frame(1'b0, DEV_TYPE_DFLT, chip_sel, 1'b1);
        m.stop();
        do_write({9'h100, 7'h00}, 130, 8'h00);
        check_prog(9'h100);
        @(negedge mclk);
        wp = 1'b1;
        repeat (4) @(negedge mclk);
        h = busy_hits;
        do_write({9'h040, 7'h00}, 2, 8'h11);
        repeat (300) @(negedge mclk);
        chk(busy_hits - h, 0);
        chk(wq.size(), 0);
        foreach (exp_v[o]) exp_v[o] = 1'b0;
        wp = 1'b0;
        // Repeated start before data, then a read address word
        addr_frame(1'b0, DEV_TYPE_DFLT, chip_sel, 1'b1);
        m.send_byte(8'h12, k); chk(k, 1);
        addr_frame(1'b1, DEV_TYPE_DFLT, chip_sel, 1'b1);
        m.stop();
        repeat (10) @(negedge mclk);
        chk(standby, 1);
        // Interrupted frame, then bus recovery
        addr_frame(1'b0, DEV_TYPE_DFLT, chip_sel, 1'b1);
        m.recover(k); chk(k, 1);
        m.send_byte({DEV_TYPE_DFLT, chip_sel, 1'b0}, k); chk(k, 1);
        m.stop();
        repeat (300) @(negedge mclk);
        chk(wq.size(), 0);
        chk(busy, 0);
        finish_test();
    end

endmodule

`default_nettype wire
